// [core/rts_pkg.sv]
// Constants for the per-timeslot receive signaling control block.
// Assumes one E1 channel with 32 timeslots and an 8-bit register port.
package rts_pkg;
  localparam int NUM_TS = 32;
  localparam int ADDR_W = 12;
  // Register array bases; entry k sits at base plus k.
  localparam logic [11:0] USER_BASE = 12'h380;
  localparam logic [11:0] CTRL_BASE = 12'h3A0;
  localparam logic [11:0] SUBST_BASE = 12'h3C0;
  localparam logic [11:0] STORE_BASE = 12'h500;
  // Values after reset.
  localparam logic [7:0] USER_RESET = 8'hFF;
  localparam logic [7:0] CTRL_RESET = 8'h00;
  localparam logic [6:0] SUBST_RESET = 7'h00;
  localparam logic [3:0] STORE_RESET = 4'h0;
  // Signaling control field positions.
  localparam int SUBST_EN_BIT = 6;
  localparam int OH_EN_BIT = 5;
  localparam int DEB_EN_BIT = 4;
  localparam int SUBST_FMT_LSB = 2;
  localparam int EXTR_FMT_LSB = 0;
  // Substitution value field positions.
  localparam int SV_A2_BIT = 6;
  localparam int SV_B4_BIT = 5;
  localparam int SV_A4_BIT = 4;
  // Channel control code that selects the user code.
  localparam logic [3:0] CHAN_USER_CODE = 4'h4;
  // Two-bit format codes shared by substitution and extraction.
  localparam logic [1:0] FMT_NONE = 2'h0;
  localparam logic [1:0] FMT_ABCD = 2'h1;
  localparam logic [1:0] FMT_AB = 2'h2;
  localparam logic [1:0] FMT_A = 2'h3;
endpackage : rts_pkg

// [core/rts_dbc_if.sv]
// Carrier between the control block and its debounce tracker.
// Assumes both ends run on sys_clk.
`timescale 1ns/1ns
`default_nettype none
interface rts_dbc_if;
  logic sample;
  logic [4:0] ts;
  logic [3:0] sig;
  logic enable;
  logic update;
  modport ctl(output sample, output ts, output sig, output enable, input update);
  modport dbc(input sample, input ts, input sig, input enable, output update);
endinterface : rts_dbc_if
`default_nettype wire

// [core/rts_debounce.sv]
// Per-timeslot signaling debounce tracker.
// Assumes one signaling sample per timeslot per superframe.
`timescale 1ns/1ns
`default_nettype none
module rts_debounce (
  input wire logic sys_clk,
  input wire logic sys_rst,
  rts_dbc_if.dbc dbc
);
  import rts_pkg::*;

  logic [3:0] prev_sig [NUM_TS];
  logic [NUM_TS-1:0] prev_ok;

  // Accept at once when debounce is off, else only on two equal superframes.
  always_comb begin
    dbc.update = dbc.sample & (~dbc.enable |
                 (prev_ok[dbc.ts] & (prev_sig[dbc.ts] == dbc.sig)));
  end

  // Keep the previous superframe's bits for each timeslot.
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      prev_ok <= '0;
      for (int i = 0; i < NUM_TS; i++) begin
        prev_sig[i] <= STORE_RESET;
      end
    end else if (dbc.sample) begin
      prev_sig[dbc.ts] <= dbc.sig;
      prev_ok[dbc.ts] <= 1'b1;
    end
  end

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (sys_rst);

  property p_deb_mismatch;
    dbc.sample && dbc.enable && prev_sig[dbc.ts] != dbc.sig |-> !dbc.update;
  endproperty
  a_deb_mismatch: assert property (p_deb_mismatch)
    else $error("Debounce passed a changed value.");

  property p_deb_off;
    dbc.sample && !dbc.enable |-> dbc.update;
  endproperty
  a_deb_off: assert property (p_deb_off)
    else $error("Undebounced sample not accepted.");

  // The framer leaves a quiet cycle between samples, so a repeat of one timeslot
  // arrives two cycles on; the quiet cycle rules out another timeslot in between.
  property p_deb_repeat;
    dbc.sample && dbc.enable ##1 !dbc.sample ##1 dbc.sample && dbc.enable &&
      $past(dbc.ts, 2) == dbc.ts && $past(dbc.sig, 2) == dbc.sig |-> dbc.update;
  endproperty
  a_deb_repeat: assert property (p_deb_repeat)
    else $error("Stable signaling not accepted.");
endmodule // rts_debounce
`default_nettype wire

// [core/rts_top.sv]
// Receive timeslot user code and signaling control for one E1 channel.
// Assumes the framer presents one timeslot per strobe, synchronous to sys_clk.
// Contract
// - Channel code 4 replaces octet with user code.
// - Thirty-two contiguous signaling control registers.
// - Bit 6 substitutes ABCD from substitution register.
// - Substitution alters PCM only, not store/pin.
// - Bit 5 drives store array onto overhead.
// - Debounce bit 4 needs two equal superframes.
// - Debounce mismatch leaves store and pin unchanged.
// - Without debounce, update immediately on change.
// - Substitution format: ones, ABCD, AB, A.
// - Extraction format: none, ABCD, AB, A.
// - Substitution values indexed by timeslot 0..31.
`timescale 1ns/1ns
`default_nettype none
module rts_top (
  input wire logic sys_clk,
  input wire logic sys_rst,
  input wire logic [rts_pkg::ADDR_W-1:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  input wire logic ts_valid,
  input wire logic [4:0] ts_index,
  input wire logic [7:0] ts_octet,
  input wire logic [3:0] ts_chan_ctrl,
  input wire logic ts_sig_valid,
  input wire logic [3:0] ts_sig,
  output logic pcm_valid,
  output logic [4:0] pcm_ts,
  output logic [7:0] rx_pcm_serial_out,
  output logic [3:0] pcm_sig,
  output logic sig_valid,
  output logic [4:0] sig_ts,
  output logic [3:0] rx_signaling_pin,
  output logic oh_valid,
  output logic [3:0] rx_overhead_pin
);
  import rts_pkg::*;

  logic [7:0] rx_user_code_array [NUM_TS];
  logic [7:0] rx_signaling_control_array [NUM_TS];
  logic [6:0] rx_signaling_substitute_values [NUM_TS];
  logic [3:0] rx_signaling_store_array [NUM_TS];
  logic [7:0] ctl;
  logic [3:0] extracted;
  logic store_we;
  logic [3:0] next_store;
  rts_dbc_if dbc_bus ();

  // True when addr falls in the 32-entry array at base; the low five bits pick the entry.
  function automatic logic in_array(input logic [11:0] addr, input logic [11:0] base);
    logic [11:0] off;
    off = addr - base;
    return (addr >= base) && (off < 12'h020);
  endfunction

  // Substitution value chosen by format; untouched bits keep the received ones.
  function automatic logic [3:0] subst_sig(input logic [1:0] fmt, input logic [6:0] sv,
                                          input logic [3:0] rx);
    case (fmt)
      FMT_NONE: subst_sig = 4'hF;
      FMT_ABCD: subst_sig = sv[3:0];
      FMT_AB: subst_sig = {sv[SV_A4_BIT], sv[SV_B4_BIT], rx[1:0]};
      default: subst_sig = {sv[SV_A2_BIT], rx[2:0]};
    endcase
  endfunction

  // Extraction mask; bits not extracted read as zero in the store.
  function automatic logic [3:0] extract_sig(input logic [1:0] fmt, input logic [3:0] rx);
    case (fmt)
      FMT_ABCD: extract_sig = rx;
      FMT_AB: extract_sig = {rx[3:2], 2'h0};
      FMT_A: extract_sig = {rx[3], 3'h0};
      default: extract_sig = 4'h0;
    endcase
  endfunction

  // Control word of the timeslot now on the signaling strobe.
  assign ctl = rx_signaling_control_array[ts_index];
  assign extracted = extract_sig(ctl[EXTR_FMT_LSB +: 2], ts_sig);

  // Hand the sample to the debounce tracker; format 00 extracts nothing.
  assign dbc_bus.sample = ts_sig_valid && ctl[EXTR_FMT_LSB +: 2] != FMT_NONE;
  assign dbc_bus.ts = ts_index;
  assign dbc_bus.sig = extracted;
  assign dbc_bus.enable = ctl[DEB_EN_BIT];
  assign store_we = dbc_bus.update;
  // The store never sees substituted bits, so the pin stays honest.
  assign next_store = store_we ? extracted : rx_signaling_store_array[ts_index];

  rts_debounce u_debounce (
    .sys_clk(sys_clk),
    .sys_rst(sys_rst),
    .dbc(dbc_bus.dbc)
  );

  // Software writes to the three writable arrays.
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      for (int i = 0; i < NUM_TS; i++) begin
        rx_user_code_array[i] <= USER_RESET;
        rx_signaling_control_array[i] <= CTRL_RESET;
        rx_signaling_substitute_values[i] <= SUBST_RESET;
      end
    end else if (reg_wr) begin
      if (in_array(reg_addr, USER_BASE)) begin
        rx_user_code_array[reg_addr[4:0]] <= reg_wdata;
      end
      if (in_array(reg_addr, CTRL_BASE)) begin
        rx_signaling_control_array[reg_addr[4:0]] <= {1'b0, reg_wdata[6:0]};
      end
      if (in_array(reg_addr, SUBST_BASE)) begin
        rx_signaling_substitute_values[reg_addr[4:0]] <= reg_wdata[6:0];
      end
    end
  end

  // Read data stands one cycle after the strobe; unmapped space reads zero.
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      reg_rdata <= 8'h00;
    end else if (!reg_rd) begin
      reg_rdata <= 8'h00;
    end else if (in_array(reg_addr, USER_BASE)) begin
      reg_rdata <= rx_user_code_array[reg_addr[4:0]];
    end else if (in_array(reg_addr, CTRL_BASE)) begin
      reg_rdata <= rx_signaling_control_array[reg_addr[4:0]];
    end else if (in_array(reg_addr, SUBST_BASE)) begin
      reg_rdata <= {1'b0, rx_signaling_substitute_values[reg_addr[4:0]]};
    end else if (in_array(reg_addr, STORE_BASE)) begin
      reg_rdata <= {4'h0, rx_signaling_store_array[reg_addr[4:0]]};
    end else begin
      reg_rdata <= 8'h00;
    end
  end

  // Signaling store; written only when debounce lets the sample through.
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      for (int i = 0; i < NUM_TS; i++) begin
        rx_signaling_store_array[i] <= STORE_RESET;
      end
    end else if (store_we) begin
      rx_signaling_store_array[ts_index] <= extracted;
    end
  end

  // PCM octet path with user code and signaling substitution.
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      pcm_valid <= 1'b0;
      pcm_ts <= 5'h00;
      rx_pcm_serial_out <= 8'h00;
      pcm_sig <= 4'h0;
    end else begin
      pcm_valid <= ts_valid;
      pcm_ts <= ts_index;
      if (ts_valid) begin
        rx_pcm_serial_out <= (ts_chan_ctrl == CHAN_USER_CODE) ?
                             rx_user_code_array[ts_index] : ts_octet;
      end
      if (ts_valid) begin
        pcm_sig <= ctl[SUBST_EN_BIT] ?
                   subst_sig(ctl[SUBST_FMT_LSB +: 2],
                             rx_signaling_substitute_values[ts_index], ts_sig) : ts_sig;
      end
    end
  end

  // Signaling pin and overhead pin both carry the stored, unsubstituted value.
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      sig_valid <= 1'b0;
      sig_ts <= 5'h00;
      rx_signaling_pin <= 4'h0;
      oh_valid <= 1'b0;
      rx_overhead_pin <= 4'h0;
    end else begin
      sig_valid <= ts_sig_valid;
      sig_ts <= ts_index;
      oh_valid <= ts_sig_valid && ctl[OH_EN_BIT];
      if (ts_sig_valid) begin
        rx_signaling_pin <= next_store;
      end
      if (ts_sig_valid && ctl[OH_EN_BIT]) begin
        rx_overhead_pin <= next_store;
      end
    end
  end

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (sys_rst);

  property p_user_code;
    ts_valid && ts_chan_ctrl == CHAN_USER_CODE && !reg_wr |=>
      rx_pcm_serial_out == rx_user_code_array[pcm_ts];
  endproperty
  a_user_code: assert property (p_user_code)
    else $error("User code not placed in octet.");

  property p_no_subst;
    ts_valid && !ctl[SUBST_EN_BIT] |=> pcm_sig == $past(ts_sig);
  endproperty
  a_no_subst: assert property (p_no_subst)
    else $error("Signaling altered while substitution is off.");

  property p_subst_ones;
    ts_valid && ctl[SUBST_EN_BIT] && ctl[SUBST_FMT_LSB +: 2] == FMT_NONE |=> pcm_sig == 4'hF;
  endproperty
  a_subst_ones: assert property (p_subst_ones)
    else $error("Format 00 did not force ones.");

  property p_pin_store;
    sig_valid |-> rx_signaling_pin == rx_signaling_store_array[sig_ts];
  endproperty
  a_pin_store: assert property (p_pin_store)
    else $error("Signaling pin differs from store.");

  property p_oh_gate;
    ts_sig_valid && !ctl[OH_EN_BIT] |=> !oh_valid && $stable(rx_overhead_pin);
  endproperty
  a_oh_gate: assert property (p_oh_gate)
    else $error("Overhead driven while disabled.");

  // Only an accepted sample is masked; a rejected one leaves the older store value,
  // which may still carry C and D from an earlier full extraction.
  property p_extract_ab;
    ts_sig_valid && ctl[EXTR_FMT_LSB +: 2] == FMT_AB && store_we |=>
      rx_signaling_pin[1:0] == 2'h0;
  endproperty
  a_extract_ab: assert property (p_extract_ab)
    else $error("AB extraction leaked C or D.");
endmodule // rts_top
`default_nettype wire

// [verif/rts_frame_model.sv]
// Behavioural model of the receive framer stream feeding the block.
// Assumes the bench calls send() from its own thread, one timeslot at a time.
`timescale 1ns/1ns
`default_nettype none
module rts_frame_model (
  input wire logic sys_clk,
  output logic ts_valid,
  output logic [4:0] ts_index,
  output logic [7:0] ts_octet,
  output logic [3:0] ts_chan_ctrl,
  output logic ts_sig_valid,
  output logic [3:0] ts_sig
);
  // Idle lines start low so the block sees defined inputs at time zero.
  initial begin
    ts_valid = 1'b0;
    ts_index = 5'h00;
    ts_octet = 8'h00;
    ts_chan_ctrl = 4'h0;
    ts_sig_valid = 1'b0;
    ts_sig = 4'h0;
  end

  // One octet and one signaling sample for a timeslot, held through the taking edge.
  // Afterwards the data lines show the inverse, so stale values never look valid.
  task automatic send(input logic [4:0] idx, input logic [7:0] oct, input logic [3:0] cc,
                      input logic [3:0] sg);
    @(posedge sys_clk);
    ts_valid <= 1'b1;
    ts_sig_valid <= 1'b1;
    ts_index <= idx;
    ts_octet <= oct;
    ts_chan_ctrl <= cc;
    ts_sig <= sg;
    @(posedge sys_clk);
    ts_valid <= 1'b0;
    ts_sig_valid <= 1'b0;
    ts_index <= ~idx;
    ts_octet <= ~oct;
    ts_chan_ctrl <= ~cc;
    ts_sig <= ~sg;
  endtask
endmodule // rts_frame_model
`default_nettype wire

// [verif/rts_top_bench.sv]
// Self-checking bench for the receive timeslot signaling control block.
// Assumes the framer model drives the stream and the bench owns the register port.
`timescale 1ns/1ns
`default_nettype none
module rts_top_bench;
  import rts_pkg::*;
  logic sys_clk = 1'b0;
  logic sys_rst = 1'b1;
  logic [11:0] reg_addr = 12'h000;
  logic [7:0] reg_wdata = 8'h00;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [7:0] reg_rdata, rx_pcm_serial_out;
  logic ts_valid, ts_sig_valid, pcm_valid, sig_valid, oh_valid;
  logic [4:0] ts_index, pcm_ts, sig_ts;
  logic [7:0] ts_octet;
  logic [3:0] ts_chan_ctrl, ts_sig, pcm_sig, rx_signaling_pin, rx_overhead_pin;
  int bad_count = 0;
  int n_checks = 0;
  int cycles = 0;

  rts_top i_dut (.sys_clk(sys_clk), .sys_rst(sys_rst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .ts_valid(ts_valid), .ts_index(ts_index), .ts_octet(ts_octet),
    .ts_chan_ctrl(ts_chan_ctrl), .ts_sig_valid(ts_sig_valid), .ts_sig(ts_sig),
    .pcm_valid(pcm_valid), .pcm_ts(pcm_ts), .rx_pcm_serial_out(rx_pcm_serial_out),
    .pcm_sig(pcm_sig), .sig_valid(sig_valid), .sig_ts(sig_ts),
    .rx_signaling_pin(rx_signaling_pin), .oh_valid(oh_valid),
    .rx_overhead_pin(rx_overhead_pin));

  rts_frame_model i_frm (.sys_clk(sys_clk), .ts_valid(ts_valid), .ts_index(ts_index),
    .ts_octet(ts_octet), .ts_chan_ctrl(ts_chan_ctrl), .ts_sig_valid(ts_sig_valid),
    .ts_sig(ts_sig));

  // 125 MHz clock.
  initial begin
    forever #4 sys_clk = ~sys_clk;
  end

  // Prints the counts and the verdict, then stops the run.
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  // A hung handshake would otherwise stall the run forever.
  always @(posedge sys_clk) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      bad_count++;
      wrap_up();
    end
  end

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    n_checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
  endtask

  // Read data stand only in the cycle after the strobe, so it is sampled there.
  task automatic rd(input logic [11:0] a, input logic [7:0] exp);
    @(posedge sys_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    #1 check(reg_rdata, exp);
  endtask

  // Sends one timeslot and lets the registered outputs settle.
  task automatic ts(input logic [4:0] k, input logic [7:0] o, input logic [3:0] c,
                    input logic [3:0] s);
    i_frm.send(k, o, c, s);
    #1;
  endtask

  task automatic t_regs();
    rd(USER_BASE + 12'h01F, USER_RESET);
    rd(CTRL_BASE + 12'h01F, CTRL_RESET);
    wr(CTRL_BASE + 12'h01F, 8'hFF);
    rd(CTRL_BASE + 12'h01F, 8'h7F);
    wr(12'h3E0, 8'h55);
    rd(12'h3E0, 8'h00);
    wr(STORE_BASE + 12'h00A, 8'h0F);
    rd(STORE_BASE + 12'h00A, 8'h00);
    wr(CTRL_BASE + 12'h01F, 8'h00);
    $display("test registers done");
  endtask

  task automatic t_user();
    wr(USER_BASE + 12'h005, 8'h5A);
    ts(5'd5, 8'hC3, CHAN_USER_CODE, 4'h0);
    check({7'h00, pcm_valid}, 8'h01);
    check(rx_pcm_serial_out, 8'h5A);
    check({3'h0, pcm_ts}, 8'h05);
    ts(5'd5, 8'hC3, 4'h0, 4'h0);
    check(rx_pcm_serial_out, 8'hC3);
    ts(5'd6, 8'h3C, CHAN_USER_CODE, 4'h0);
    check(rx_pcm_serial_out, USER_RESET);
    $display("test user code done");
  endtask

  task automatic t_subst();
    logic [3:0] exp [4];
    exp = '{4'hF, 4'h5, 4'hE, 4'h2};
    wr(SUBST_BASE + 12'h002, 8'h35);
    rd(SUBST_BASE + 12'h002, 8'h35);
    for (int f = 0; f < 4; f++) begin
      wr(CTRL_BASE + 12'h002, 8'h41 | (8'(f) << SUBST_FMT_LSB));
      ts(5'd2, 8'h00, 4'h0, 4'hA);
      check({4'h0, pcm_sig}, {4'h0, exp[f]});
      check({4'h0, rx_signaling_pin}, 8'h0A);
    end
    rd(STORE_BASE + 12'h002, 8'h0A);
    wr(CTRL_BASE + 12'h002, 8'h01);
    ts(5'd2, 8'h00, 4'h0, 4'hA);
    check({4'h0, pcm_sig}, 8'h0A);
    $display("test substitution done");
  endtask

  task automatic t_oh_extract();
    wr(CTRL_BASE + 12'h004, 8'h21);
    ts(5'd4, 8'h00, 4'h0, 4'h6);
    check({7'h00, oh_valid}, 8'h01);
    check({4'h0, rx_overhead_pin}, 8'h06);
    wr(CTRL_BASE + 12'h004, 8'h01);
    ts(5'd4, 8'h00, 4'h0, 4'h9);
    check({7'h00, oh_valid}, 8'h00);
    check({4'h0, rx_overhead_pin}, 8'h06);
    wr(CTRL_BASE + 12'h009, 8'h01);
    ts(5'd9, 8'h00, 4'h0, 4'hD);
    check({3'h0, sig_ts}, 8'h09);
    check({4'h0, rx_signaling_pin}, 8'h0D);
    wr(CTRL_BASE + 12'h009, 8'h02);
    ts(5'd9, 8'h00, 4'h0, 4'h7);
    check({4'h0, rx_signaling_pin}, 8'h04);
    wr(CTRL_BASE + 12'h009, 8'h03);
    ts(5'd9, 8'h00, 4'h0, 4'hB);
    check({4'h0, rx_signaling_pin}, 8'h08);
    wr(CTRL_BASE + 12'h009, 8'h00);
    ts(5'd9, 8'h00, 4'h0, 4'h5);
    rd(STORE_BASE + 12'h009, 8'h08);
    $display("test overhead and extraction done");
  endtask

  task automatic t_debounce();
    logic [3:0] smp [4];
    logic [3:0] pin [4];
    smp = '{4'h9, 4'h9, 4'h6, 4'h6};
    pin = '{4'h0, 4'h9, 4'h9, 4'h6};
    wr(CTRL_BASE + 12'h007, 8'h11);
    for (int i = 0; i < 4; i++) begin
      ts(5'd7, 8'h00, 4'h0, smp[i]);
      check({4'h0, rx_signaling_pin}, {4'h0, pin[i]});
    end
    rd(STORE_BASE + 12'h007, 8'h06);
    wr(CTRL_BASE + 12'h008, 8'h01);
    ts(5'd8, 8'h00, 4'h0, 4'h3);
    check({7'h00, sig_valid}, 8'h01);
    check({4'h0, rx_signaling_pin}, 8'h03);
    $display("test debounce done");
  endtask

  // Reset for twelve cycles, then each scenario in turn.
  initial begin
    repeat (12) @(posedge sys_clk);
    sys_rst <= 1'b0;
    t_regs();
    t_user();
    t_subst();
    t_oh_extract();
    t_debounce();
    wrap_up();
  end
endmodule // rts_top_bench
`default_nettype wire
